// *** brpc_pkg.sv ***
// Package with constants and types for the bridge reset and power control
// Contract
// - Downstream clocks follow upstream clock, same frequency
// - D0-D3cold supported; D1 gives B1, D2/D3hot B2
// - D0 to D3hot with enable stops clocks low
// - D0 to D2 with enable stops clocks low
// - In D1 accept only type 0 config
// - D3hot to D0 restarts clocks, internal reset only
// - D3cold leaves only through power-up reset
// - Wake events are never forwarded
// - Upstream reset floats upstream, drives downstream low
// - Upstream reset resets every defaulted register
// - Upstream reset and downstream reset act clocklessly; here only the pins do, registers and flush use clk_i
// - Ignore accesses through reset plus 16 clocks
// - Downstream reset follows upstream reset
// - Downstream reset bit holds reset until cleared
// - Downstream reset floats control, drives data low
// - Downstream reset flushes posted and delayed buffers
// - Bit-caused downstream reset keeps config accessible
// - Chip reset bit resets all, sets downstream bit
// - Chip reset self-clears within 20 clocks after clear
// - No access response during chip reset
package brpc_pkg;
   localparam int unsigned brpc_clk_mhz = 100;
   localparam int unsigned brpc_post_reset_clks = 16;
   localparam int unsigned brpc_chip_clear_clks = 20;
   localparam int unsigned brpc_nclk = 5;
   localparam logic [7:0] brpc_reg_pmcsr = 8'h00;
   localparam logic [7:0] brpc_reg_bridge = 8'h04;
   localparam logic [7:0] brpc_reg_chip = 8'h08;
   localparam logic [7:0] brpc_reg_status = 8'h0c;
   localparam int unsigned brpc_pm_lsb = 0;
   localparam int unsigned brpc_bus_rst_bit = 0;
   localparam int unsigned brpc_chip_rst_bit = 0;
   localparam logic [1:0] brpc_pm_reset = 2'h0;

   typedef enum logic [1:0] {
      brpc_d0 = 2'h0,
      brpc_d1 = 2'h1,
      brpc_d2 = 2'h2,
      brpc_d3hot = 2'h3
   } brpc_pstate_type;

   typedef enum logic [1:0] {
      brpc_b0 = 2'h0,
      brpc_b1 = 2'h1,
      brpc_b2 = 2'h3
   } brpc_bstate_type;

   typedef enum logic [1:0] {
      brpc_run = 2'h0,
      brpc_chip_hold = 2'h1,
      brpc_chip_drain = 2'h3
   } brpc_chip_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
      logic type0_cfg;
   } brpc_req_type;

   typedef struct packed {
      logic upstream_oe;
      logic down_ctrl_oe;
      logic down_data_oe;
      logic down_bus_rst_n;
   } brpc_pins_type;
endpackage : brpc_pkg

// *** brpc_sync.sv ***
// Two-stage reset release synchroniser
`timescale 1ns/1ps
module brpc_sync (
   input wire logic clk_i,
   input wire logic async_rst_b_i,
   output logic sync_rst_b_o
);
   logic stage;
   // Assert at once, release only on a clock edge
   always_ff @(posedge clk_i or negedge async_rst_b_i) begin
      if (!async_rst_b_i) begin
         stage <= 1'b0;
         sync_rst_b_o <= 1'b0;
      end else begin
         stage <= 1'b1;
         sync_rst_b_o <= stage;
      end
   end
endmodule : brpc_sync

// *** brpc_count.sv ***
// Saturating down counter that reports when it has expired
`timescale 1ns/1ps
module brpc_count #(
   parameter int unsigned LOAD = 16
) (
   input wire logic clk_i,
   input wire logic load_i,
   output logic done_o
);
   localparam int unsigned W = $clog2(LOAD + 1);
   logic [W-1:0] cnt;
   // Elaboration-time refusal of a load the counter cannot serve
   if (LOAD < 1) begin : g_bad_load
      $error("brpc_count: LOAD must be at least 1");
   end
   always_ff @(posedge clk_i) begin
      if (load_i) begin
         cnt <= W'(LOAD);
      end else if (cnt != '0) begin
         cnt <= cnt - W'(1);
      end
   end
   assign done_o = (cnt == '0) && !load_i;
endmodule : brpc_count

// *** brpc_top.sv ***
// Reset sequencing, power states and clock gating of the bridge
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module brpc_top (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic upstream_rst_b_i,
   input wire logic clock_stop_enable_input_i,
   input wire logic clock_stop_enable_input_alt_i,
   input wire brpc_pkg::brpc_req_type req_i,
   output logic [31:0] rdata_o,
   output logic access_ok_o,
   output logic [brpc_pkg::brpc_nclk-1:0] downstream_clock_outputs_o,
   output brpc_pkg::brpc_pins_type pins_o,
   output logic buffer_flush_o,
   output logic internal_reset_o,
   output brpc_pkg::brpc_bstate_type bus_state_o
);
   import brpc_pkg::*;

   logic up_rst_b_sync;
   logic up_rst_b_q;
   logic post_done;
   logic chip_done;
   logic chip_load;
   logic cold_b;
   brpc_pstate_type pstate;
   brpc_pstate_type next_pstate;
   brpc_chip_type chip;
   logic bus_rst_bit;
   logic chip_rst_bit;
   logic clk_stop;
   logic pm_reset_pulse;
   logic soft_reset;
   logic req_seen;
   logic bus_rst_bit_wr_clear;
   logic accept;
   logic [31:0] next_rdata;

   // Power-up reset gives D3cold exit; upstream reset takes the same path back to D0
   assign cold_b = rst_b_i && upstream_rst_b_i;

   brpc_sync u_sync (
      .clk_i(clk_i),
      .async_rst_b_i(cold_b),
      .sync_rst_b_o(up_rst_b_sync)
   );

   brpc_count #(.LOAD(brpc_post_reset_clks)) u_post (
      .clk_i(clk_i),
      .load_i(!up_rst_b_sync),
      .done_o(post_done)
   );

   assign chip_load = (chip == brpc_chip_hold);
   // Two clocks of the budget go to the step into run and the first
   // accepting edge, so the drain count is two short of the limit
   brpc_count #(.LOAD(brpc_chip_clear_clks - 2)) u_chip (
      .clk_i(clk_i),
      .load_i(chip_load),
      .done_o(chip_done)
   );

   always_ff @(posedge clk_i) begin
      up_rst_b_q <= up_rst_b_sync;
   end

   // Internal reset on D3hot to D0 and while chip reset runs
   assign soft_reset = pm_reset_pulse || (chip != brpc_run);

   // Access acceptance; D1 limits to type 0 configuration
   always_comb begin
      accept = up_rst_b_q && post_done && (chip == brpc_run);
      if (pstate == brpc_d1 && !req_i.type0_cfg) begin
         accept = 1'b0;
      end
   end
   assign req_seen = accept && (req_i.wr || req_i.rd);

   // Power state register
   always_comb begin
      next_pstate = pstate;
      if (req_seen && req_i.wr && req_i.addr == brpc_reg_pmcsr) begin
         next_pstate = brpc_pstate_type'(req_i.wdata[brpc_pm_lsb +: 2]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!up_rst_b_sync || soft_reset) begin
         pstate <= brpc_d0;
      end else begin
         pstate <= next_pstate;
      end
   end

   // One-cycle internal reset on leaving D3hot for D0
   always_ff @(posedge clk_i) begin
      if (!up_rst_b_sync) begin
         pm_reset_pulse <= 1'b0;
      end else begin
         pm_reset_pulse <= (pstate == brpc_d3hot) &&
            (next_pstate == brpc_d0) && !soft_reset;
      end
   end

   // Clock stop chosen on entry from D0 to D3hot or D2
   always_ff @(posedge clk_i) begin
      if (!up_rst_b_sync || soft_reset) begin
         clk_stop <= 1'b0;
      end else if (pstate == brpc_d0 && next_pstate == brpc_d3hot) begin
         clk_stop <= clock_stop_enable_input_i;
      end else if (pstate == brpc_d0 && next_pstate == brpc_d2) begin
         clk_stop <= clock_stop_enable_input_alt_i;
      end else if (next_pstate == brpc_d0 || next_pstate == brpc_d1) begin
         clk_stop <= 1'b0;
      end
   end

   // Downstream reset bit; chip reset sets it, a write, upstream reset or the D3hot to D0 internal reset clears it
   always_ff @(posedge clk_i) begin
      if (!up_rst_b_sync || pm_reset_pulse) begin
         bus_rst_bit <= 1'b0;
      end else if (chip == brpc_chip_hold) begin
         // Set by chip reset; the clearing write must still win here
         bus_rst_bit <= !bus_rst_bit_wr_clear;
      end else if (req_seen && req_i.wr && req_i.addr == brpc_reg_bridge) begin
         bus_rst_bit <= req_i.wdata[brpc_bus_rst_bit];
      end
   end

   // Chip reset: hold while downstream bit set, then drain and clear
   always_ff @(posedge clk_i) begin
      if (!up_rst_b_sync) begin
         chip <= brpc_run;
         chip_rst_bit <= 1'b0;
      end else begin
         unique case (chip)
            brpc_run: begin
               if (req_seen && req_i.wr && req_i.addr == brpc_reg_chip &&
                   req_i.wdata[brpc_chip_rst_bit]) begin
                  chip_rst_bit <= 1'b1;
                  chip <= brpc_chip_hold;
               end
            end
            brpc_chip_hold: begin
               if (bus_rst_bit_wr_clear) begin
                  chip <= brpc_chip_drain;
               end
            end
            brpc_chip_drain: begin
               if (chip_done) begin
                  chip_rst_bit <= 1'b0;
                  chip <= brpc_run;
               end
            end
            default: chip <= brpc_run;
         endcase
      end
   end

   // The clearing write is the only access allowed during chip hold
   assign bus_rst_bit_wr_clear = up_rst_b_q && req_i.wr &&
      req_i.addr == brpc_reg_bridge && !req_i.wdata[brpc_bus_rst_bit];

   // Read data one cycle after the read strobe; unmapped reads give zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (req_i.addr)
         brpc_reg_pmcsr: next_rdata[1:0] = pstate;
         brpc_reg_bridge: next_rdata[0] = bus_rst_bit;
         brpc_reg_chip: next_rdata[0] = chip_rst_bit;
         brpc_reg_status: next_rdata[3:0] = {clk_stop, bus_state_o, post_done};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!up_rst_b_sync) begin
         rdata_o <= 32'h0000_0000;
      end else if (req_seen && req_i.rd) begin
         rdata_o <= next_rdata;
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   // Bit-caused downstream reset leaves configuration reachable
   always_ff @(posedge clk_i) begin
      if (!up_rst_b_sync) begin
         access_ok_o <= 1'b0;
      end else begin
         access_ok_o <= accept;
      end
   end

   // Gated downstream clocks: a stopped clock is held low. The enable
   // is a registered level, so the gate is a plain AND on clk_i.
   logic clk_gate;
   always_ff @(negedge clk_i) begin
      clk_gate <= !clk_stop;
   end
   assign downstream_clock_outputs_o = {brpc_nclk{clk_i & clk_gate}};

   // Downstream power state follows device state
   always_ff @(posedge clk_i) begin
      if (!up_rst_b_sync) begin
         bus_state_o <= brpc_b0;
      end else if (pstate == brpc_d1) begin
         bus_state_o <= brpc_b1;
      end else if (pstate == brpc_d2 || pstate == brpc_d3hot) begin
         bus_state_o <= brpc_b2;
      end else begin
         bus_state_o <= brpc_b0;
      end
   end

   // Pin control. Upstream reset acts through the asynchronous arm of
   // the synchroniser, so floating starts without waiting for an edge.
   always_comb begin
      pins_o.upstream_oe = up_rst_b_sync && (chip == brpc_run);
      pins_o.down_bus_rst_n = up_rst_b_sync && !bus_rst_bit &&
         !chip_rst_bit;
      pins_o.down_ctrl_oe = pins_o.down_bus_rst_n;
      pins_o.down_data_oe = 1'b1;
   end

   // Flush of posted and delayed buffers
   always_ff @(posedge clk_i) begin
      buffer_flush_o <= !up_rst_b_sync || bus_rst_bit || soft_reset;
   end

   always_ff @(posedge clk_i) begin
      internal_reset_o <= !up_rst_b_sync || soft_reset;
   end

   // Wake events from below are routed around this block, never in it
endmodule : brpc_top

// *** brpc_checker.sv ***
// Port assertions for the reset and power control block
`timescale 1ns/1ps
module brpc_checker (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic upstream_rst_b_i,
   input wire brpc_pkg::brpc_req_type req_i,
   input wire logic [31:0] rdata_o,
   input wire logic access_ok_o,
   input wire brpc_pkg::brpc_pins_type pins_o,
   input wire logic buffer_flush_o
);
   import brpc_pkg::*;
   default clocking @(posedge clk_i); endclocking
   // Power-up reset only: upstream reset must stay observable
   default disable iff (!rst_b_i);
   a_down_rst_follow: assert property (
      !upstream_rst_b_i |-> !pins_o.down_bus_rst_n)
      else $error("downstream reset not held with upstream reset");
   a_up_float: assert property (
      !upstream_rst_b_i |-> !pins_o.upstream_oe)
      else $error("upstream pins driven during reset");
   a_no_access: assert property (
      !upstream_rst_b_i |=> !access_ok_o)
      else $error("access accepted during upstream reset");
   a_post_quiet: assert property (
      $rose(upstream_rst_b_i) |-> (!access_ok_o)[*8] ##1 (!access_ok_o)[*8])
      else $error("access accepted too soon after reset");
   a_refused_read: assert property (
      !access_ok_o && req_i.rd |=> rdata_o == 32'h0)
      else $error("refused read returned data");
   a_flush_on_rst: assert property (
      $fell(pins_o.down_bus_rst_n) |-> ##[0:2] buffer_flush_o)
      else $error("buffers not flushed on downstream reset");
   a_ctrl_float: assert property (
      !pins_o.down_bus_rst_n |-> !pins_o.down_ctrl_oe)
      else $error("downstream control driven during reset");
   a_data_low: assert property (
      !pins_o.down_bus_rst_n |-> pins_o.down_data_oe)
      else $error("downstream data not driven during reset");
endmodule : brpc_checker

bind brpc_top brpc_checker brpc_checker_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
   .upstream_rst_b_i(upstream_rst_b_i), .req_i(req_i), .rdata_o(rdata_o),
   .access_ok_o(access_ok_o), .pins_o(pins_o),
   .buffer_flush_o(buffer_flush_o));

// *** brpc_host.sv ***
// Upstream host model issuing configuration transfers
`timescale 1ns/1ps
module brpc_host (
   input wire logic clk_i,
   input wire logic [31:0] rdata_i,
   output brpc_pkg::brpc_req_type req_o
);
   import brpc_pkg::*;
   initial req_o = '0;
   task automatic xfer(input logic [7:0] a, input logic [31:0] d,
      input logic w, input logic t0, output logic [31:0] q);
      @(posedge clk_i);
      req_o <= '{addr: a, wdata: d, wr: w, rd: !w, type0_cfg: t0};
      @(posedge clk_i);
      // Released fields flip so a stale value can never pass
      req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0, type0_cfg: !t0};
      #1 q = rdata_i;
   endtask : xfer
endmodule : brpc_host

// *** testbench.sv ***
// Self-checking bench for the reset and power control block
`timescale 1ns/1ps
module testbench;
   import brpc_pkg::*;
   logic clk_i = 0, rst_b_i = 0, up_rst_b = 0, cse = 0, cse_alt = 0;
   brpc_req_type req;
   logic [31:0] rdata, q;
   logic access_ok, flush, int_rst;
   logic [brpc_nclk-1:0] dclk;
   brpc_pins_type pins;
   brpc_bstate_type bstate;
   int bad_count = 0, n_compared = 0, n;
   always #5 clk_i = ~clk_i;
   brpc_host brpc_host_i (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
   brpc_top brpc_top_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .upstream_rst_b_i(up_rst_b), .clock_stop_enable_input_i(cse),
      .clock_stop_enable_input_alt_i(cse_alt), .req_i(req),
      .rdata_o(rdata), .access_ok_o(access_ok),
      .downstream_clock_outputs_o(dclk), .pins_o(pins),
      .buffer_flush_o(flush), .internal_reset_o(int_rst),
      .bus_state_o(bstate));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic print_verdict;
      if (bad_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   task automatic wait_ok(output int cnt);
      cnt = 0;
      while (access_ok !== 1'b1) begin
         @(posedge clk_i);
         #1 cnt++;
         if (cnt > 200) begin
            bad_count++;
            print_verdict();
         end
      end
   endtask : wait_ok
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      brpc_host_i.xfer(a, d, 1'b1, 1'b1, q);
   endtask : wr
   task automatic cycles(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask : cycles
   task automatic t_power;
      logic seen, held;
      wr(brpc_reg_pmcsr, 32'h3);
      cycles(3);
      check(dclk, '0);
      check(bstate, brpc_b2);
      wr(brpc_reg_pmcsr, 32'h0);
      seen = 0;
      held = 1;
      for (int i = 0; i < 4; i++) begin
         seen |= int_rst;
         held &= pins.down_bus_rst_n;
         cycles(1);
      end
      check(seen, 1);
      check(held, 1);
      check(dclk, 5'h1f);
      wait_ok(n);
      wr(brpc_reg_pmcsr, 32'h2);
      cycles(3);
      check(dclk, '0);
      check(bstate, brpc_b2);
      wr(brpc_reg_pmcsr, 32'h1);
      cycles(2);
      check(bstate, brpc_b1);
      brpc_host_i.xfer(brpc_reg_pmcsr, 32'h0, 1'b0, 1'b0, q);
      check(q, 0);
      brpc_host_i.xfer(brpc_reg_pmcsr, 32'h0, 1'b0, 1'b1, q);
      check(q[1:0], 1);
      wr(brpc_reg_pmcsr, 32'h0);
   endtask : t_power
   task automatic t_bus_rst;
      wr(brpc_reg_bridge, 32'h1);
      cycles(2);
      check(pins.down_bus_rst_n, 0);
      check(flush, 1);
      brpc_host_i.xfer(brpc_reg_bridge, 32'h0, 1'b0, 1'b1, q);
      check(q[0], 1);
      wr(brpc_reg_bridge, 32'h0);
      cycles(3);
      check(pins.down_bus_rst_n, 1);
   endtask : t_bus_rst
   task automatic t_chip;
      wr(brpc_reg_chip, 32'h1);
      cycles(2);
      check(pins.down_bus_rst_n, 0);
      check(access_ok, 0);
      brpc_host_i.xfer(brpc_reg_pmcsr, 32'h0, 1'b0, 1'b1, q);
      check(q, 0);
      wr(brpc_reg_bridge, 32'h0);
      wait_ok(n);
      check(n <= brpc_chip_clear_clks, 1);
      brpc_host_i.xfer(brpc_reg_chip, 32'h0, 1'b0, 1'b1, q);
      check(q[0], 0);
   endtask : t_chip
   task automatic t_up_rst;
      wr(brpc_reg_pmcsr, 32'h2);
      @(posedge clk_i);
      up_rst_b <= 0;
      #1 check(pins.upstream_oe, 0);
      check(pins.down_bus_rst_n, 0);
      repeat (4) @(posedge clk_i);
      up_rst_b <= 1;
      cycles(1);
      wait_ok(n);
      check(n >= brpc_post_reset_clks, 1);
      brpc_host_i.xfer(brpc_reg_pmcsr, 32'h0, 1'b0, 1'b1, q);
      check(q[1:0], brpc_pm_reset);
   endtask : t_up_rst
   task automatic t_cold;
      @(posedge clk_i);
      cse <= 0;
      wr(brpc_reg_pmcsr, 32'h3);
      cycles(3);
      check(dclk, 5'h1f);
      @(posedge clk_i);
      rst_b_i <= 0;
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1;
      cycles(1);
      wait_ok(n);
      check(n >= brpc_post_reset_clks, 1);
      check(dclk, 5'h1f);
      brpc_host_i.xfer(brpc_reg_pmcsr, 32'h0, 1'b0, 1'b1, q);
      check(q[1:0], brpc_pm_reset);
   endtask : t_cold
   initial begin
      repeat (12) @(posedge clk_i);
      rst_b_i <= 1;
      up_rst_b <= 1;
      cse <= 1;
      cse_alt <= 1;
      wait_ok(n);
      check(n >= brpc_post_reset_clks, 1);
      t_power();
      t_bus_rst();
      t_chip();
      t_up_rst();
      t_cold();
      print_verdict();
   end
endmodule : testbench
